// ---- src/sel_pkg.sv ----
package sel_pkg;

	//////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ      = 25000000;
	localparam int unsigned TICK_MS     = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned ALARM_MS    = 3000;
	localparam int unsigned ALARM_TICKS = ALARM_MS / TICK_MS;
	localparam int unsigned AL_W        = 5;
	localparam int unsigned TO_W        = 10;

	localparam logic [TO_W-1:0] TIMEOUT_MIN = 10'h01e;
	localparam logic [TO_W-1:0] TIMEOUT_MAX = 10'h258;
	localparam logic [TO_W-1:0] TIMEOUT_RST = 10'h032;
	localparam logic [2:0]      LIMIT_MIN   = 3'h1;
	localparam logic [2:0]      LIMIT_RST   = 3'h7;
	localparam logic [1:0]      INIT_WAIT   = 2'h3;
	localparam logic [2:0]      POS_NONE    = 3'h0;
	localparam logic [2:0]      POS_FIRST   = 3'h1;
	localparam logic [2:0]      BANK_DEFAULT = 3'h1;
	localparam int unsigned     BANKS       = 6;
	localparam int unsigned     POSITIONS   = 7;

	//////////////////////////////////////////////////////////////////////////
	// register map
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LIMIT   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_TIMEOUT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0c;

	localparam int unsigned CTRL_INC_ACK  = 0;
	localparam int unsigned CTRL_CODE_ACK = 1;
	localparam int unsigned CTRL_POLICY   = 2;
	localparam int unsigned ST_POS        = 0;
	localparam int unsigned ST_PRE        = 4;
	localparam int unsigned ST_BANK       = 8;
	localparam int unsigned ST_INC_BUSY   = 12;
	localparam int unsigned ST_CODE_BUSY  = 13;
	localparam int unsigned ST_RANGE_AL   = 16;
	localparam int unsigned ST_INC_AL     = 17;
	localparam int unsigned ST_CODE_AL    = 18;
	localparam int unsigned ST_PWR_AL     = 19;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	//////////////////////////////////////////////////////////////////////////
	// synchronised pin vector
	localparam int unsigned PIN_INC      = 0;
	localparam int unsigned PIN_INC_ACK  = 1;
	localparam int unsigned PIN_CODE     = 2;
	localparam int unsigned PIN_CODE_ACK = 5;
	localparam int unsigned PIN_BLOCK    = 6;
	localparam int unsigned PIN_REQ      = 7;
	localparam int unsigned PIN_NV       = 12;
	localparam int unsigned PIN_W        = 15;

	typedef enum logic [1:0] {PWR_RESTORE, PWR_SYNC, PWR_SYNC_RESTORE} pwr_policy_t;
	localparam pwr_policy_t POLICY_RST = PWR_RESTORE;

	typedef enum logic [1:0] {S_INIT, S_IDLE, S_INC, S_CODE} seq_t;

endpackage

// ---- src/position_selector_group_arbiter.sv ----
`timescale 1ns/100ps
`default_nettype none

// Operation
// - highest requested bank wins, one active
// - bank 1 active when nothing requested
// - block input freezes the active bank
// - upper position limit settable 1 to 7
// - increment edge steps, wraps limit to 1
// - timeout 3.0 to 60.0 s, 0.1 s
// - increment edge restarts the timeout
// - timeout mode commits after idle timeout
// - confirm mode: timeout bounds the confirm
// - increment confirm edge commits in confirm mode
// - no increment confirm: discard, 3 s alarm
// - code 1..7 preselects, zero is rest
// - code above limit: no change, 3 s alarm
// - code timeout mode commits after timeout
// - no code confirm: cancel, 3 s alarm
// - separate confirm input and mode per path
// - running sequence locks out the other path
// - committed position kept in non-volatile store
// - power-up policy restore, sync, sync/restore
// - sync adopts code at once, bad code alarms
// - bad restored position gives 0, alarm
module position_selector_group_arbiter #(
	parameter int unsigned TICK_CYCLES_P = sel_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// axi4-lite slave
	input  wire logic [sel_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [sel_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// selector control inputs
	input  wire logic                        increment_in,
	input  wire logic                        increment_confirm,
	input  wire logic                        code_bit_zero,
	input  wire logic                        code_bit_one,
	input  wire logic                        code_bit_two,
	input  wire logic                        code_confirm_input,
	// bank arbiter inputs, banks 2 to 6
	input  wire logic                        group_change_block,
	input  wire logic [sel_pkg::BANKS-2:0]   bank_request,
	// non-volatile position store
	input  wire logic [2:0]                  nv_position,
	output logic                             nv_write,
	output logic [2:0]                       nv_write_data,
	// selector outputs
	output logic [sel_pkg::POSITIONS-1:0]    position_onehot,
	output logic [2:0]                       position_code,
	output logic [2:0]                       bank_active,
	output logic [sel_pkg::BANKS-1:0]        bank_onehot,
	// alarms
	output logic                             range_alarm,
	output logic                             increment_confirm_alarm,
	output logic                             code_confirm_alarm,
	output logic                             powerup_alarm
);
	import sel_pkg::*;

	localparam int unsigned TW = $clog2(TICK_CYCLES_P);

	typedef struct packed {
		logic [PIN_W-1:0]  sync1;
		logic [PIN_W-1:0]  sync2;
		logic [PIN_W-1:0]  prev;
		logic [TW-1:0]     tick_cnt;
		logic              tick;
		seq_t              seq;
		logic [1:0]        init_cnt;
		logic [TO_W-1:0]   timer;
		logic [AL_W-1:0]   range_cnt;
		logic [AL_W-1:0]   inc_cnt;
		logic [AL_W-1:0]   code_cnt;
		logic              pwr_alarm;
		logic [2:0]        pre;
		logic [2:0]        pos;
		logic [2:0]        bank;
		logic              nv_we;
		logic [2:0]        nv_data;
		logic              inc_ack_mode;
		logic              code_ack_mode;
		pwr_policy_t       policy;
		logic [2:0]        limit;
		logic [TO_W-1:0]   timeout;
		logic              aw_full;
		logic [ADDR_W-1:0] awaddr;
		logic              w_full;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_t;

	localparam logic [TW-1:0]   TICK_LAST = TW'(TICK_CYCLES_P - 1);
	localparam logic [AL_W-1:0] ALARM_LD  = AL_W'(ALARM_TICKS);

	state_t q;
	state_t d;

	////////////////////////////////////////////////////////////////////////////
	// register read view, shared by read channel and write merge

	function automatic logic [32:0] reg_read(input state_t s, input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		logic        ok;
		v  = 32'h0;
		ok = 1'b1;
		unique case (a)
			OFF_CTRL: begin
				v[CTRL_INC_ACK]        = s.inc_ack_mode;
				v[CTRL_CODE_ACK]       = s.code_ack_mode;
				v[CTRL_POLICY +: 2]    = s.policy;
			end
			OFF_LIMIT:   v[2:0] = s.limit;
			OFF_TIMEOUT: v[TO_W-1:0] = s.timeout;
			OFF_STATUS: begin
				v[ST_POS +: 3]   = s.pos;
				v[ST_PRE +: 3]   = s.pre;
				v[ST_BANK +: 3]  = s.bank;
				v[ST_INC_BUSY]   = (s.seq == S_INC);
				v[ST_CODE_BUSY]  = (s.seq == S_CODE);
				v[ST_RANGE_AL]   = (s.range_cnt != '0);
				v[ST_INC_AL]     = (s.inc_cnt != '0);
				v[ST_CODE_AL]    = (s.code_cnt != '0);
				v[ST_PWR_AL]     = s.pwr_alarm;
			end
			default: ok = 1'b0;
		endcase
		return {ok, v};
	endfunction

	// wrap at the limit; position 0 (nothing selected) steps to 1
	function automatic logic [2:0] step_up(input logic [2:0] p, input logic [2:0] lim);
		return (p >= lim || p == POS_NONE) ? POS_FIRST : p + 3'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [2:0]  code;
		logic        code_chg;
		logic        inc_rise;
		logic        inc_ack_rise;
		logic        code_ack_rise;
		logic        expire;
		logic        commit;
		logic [32:0] rd;
		logic [32:0] cur;
		logic [31:0] merged;
		logic [BANKS-2:0] req;
		code          = 3'h0;
		code_chg      = 1'b0;
		inc_rise      = 1'b0;
		inc_ack_rise  = 1'b0;
		code_ack_rise = 1'b0;
		expire        = 1'b0;
		commit        = 1'b0;
		rd            = 33'h0;
		cur           = 33'h0;
		merged        = 32'h0;
		req           = '0;
		d             = q;

		// pins pass two flops, edges against the prior sample
		d.sync1 = {nv_position, bank_request, group_change_block, code_confirm_input,
			code_bit_two, code_bit_one, code_bit_zero, increment_confirm, increment_in};
		d.sync2 = q.sync1;
		d.prev  = q.sync2;
		code          = q.sync2[PIN_CODE +: 3];
		code_chg      = code != q.prev[PIN_CODE +: 3];
		inc_rise      = q.sync2[PIN_INC] & ~q.prev[PIN_INC];
		inc_ack_rise  = q.sync2[PIN_INC_ACK] & ~q.prev[PIN_INC_ACK];
		code_ack_rise = q.sync2[PIN_CODE_ACK] & ~q.prev[PIN_CODE_ACK];

		// coarse 0.1 s tick
		d.tick = 1'b0;
		if (q.tick_cnt == TICK_LAST) begin
			d.tick_cnt = '0;
			d.tick     = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + TW'(1);
		end

		// alarm hold counters
		if (q.tick) begin
			if (q.range_cnt != '0) d.range_cnt = q.range_cnt - AL_W'(1);
			if (q.inc_cnt != '0)   d.inc_cnt   = q.inc_cnt - AL_W'(1);
			if (q.code_cnt != '0)  d.code_cnt  = q.code_cnt - AL_W'(1);
		end

		// sequence timer; expiry falls on the tick that empties it
		if (q.tick && q.seq inside {S_INC, S_CODE}) begin
			if (q.timer <= TO_W'(1)) begin
				expire = 1'b1;
			end else begin
				d.timer = q.timer - TO_W'(1);
			end
		end

		d.nv_we = 1'b0;
		unique case (q.seq)
			S_INIT: begin
				// wait until the synchronisers hold real samples
				if (q.init_cnt != INIT_WAIT) begin
					d.init_cnt = q.init_cnt + 2'h1;
				end else begin
					d.seq = S_IDLE;
					if ((q.policy == PWR_SYNC || q.policy == PWR_SYNC_RESTORE) &&
						code != POS_NONE && code <= q.limit) begin
						d.pos = code;
						d.pre = code;
					end else if (q.policy == PWR_SYNC) begin
						d.pos       = POS_NONE;
						d.pwr_alarm = 1'b1;
					end else if (q.sync2[PIN_NV +: 3] != POS_NONE &&
						q.sync2[PIN_NV +: 3] <= q.limit) begin
						d.pos = q.sync2[PIN_NV +: 3];
						d.pre = q.sync2[PIN_NV +: 3];
					end else begin
						d.pos       = POS_NONE;
						d.pwr_alarm = 1'b1;
					end
				end
			end
			S_IDLE: begin
				if (inc_rise) begin
					d.pre   = step_up(q.pos, q.limit);
					d.timer = q.timeout;
					d.seq   = S_INC;
				end else if (code_chg && code != POS_NONE) begin
					if (code > q.limit) begin
						d.range_cnt = ALARM_LD;
					end else begin
						d.pre   = code;
						d.timer = q.timeout;
						d.seq   = S_CODE;
					end
				end
			end
			S_INC: begin
				// code inputs are not looked at here
				if (inc_rise) begin
					d.pre   = step_up(q.pre, q.limit);
					d.timer = q.timeout;
				end else if (q.inc_ack_mode && inc_ack_rise) begin
					commit = 1'b1;
				end else if (expire) begin
					if (q.inc_ack_mode) begin
						d.seq     = S_IDLE;
						d.pre     = q.pos;
						d.inc_cnt = ALARM_LD;
					end else begin
						commit = 1'b1;
					end
				end
			end
			S_CODE: begin
				// increment input is locked out until this ends
				if (code_chg && code != POS_NONE) begin
					if (code > q.limit) begin
						d.range_cnt = ALARM_LD;
					end else begin
						d.pre   = code;
						d.timer = q.timeout;
					end
				end else if (q.code_ack_mode && code_ack_rise) begin
					commit = 1'b1;
				end else if (expire) begin
					if (q.code_ack_mode) begin
						d.seq      = S_IDLE;
						d.pre      = q.pos;
						d.code_cnt = ALARM_LD;
					end else begin
						commit = 1'b1;
					end
				end
			end
		endcase

		if (commit) begin
			d.seq       = S_IDLE;
			d.pos       = q.pre;
			d.pwr_alarm = 1'b0;
			d.nv_we     = 1'b1;
			d.nv_data   = q.pre;
		end

		// bank arbiter: external requests or-ed with the selector position
		for (int k = 0; k < BANKS - 1; k++) begin
			req[k] = q.sync2[PIN_REQ + k] | (q.pos == 3'(k + 2));
		end
		if (!q.sync2[PIN_BLOCK]) begin
			d.bank = BANK_DEFAULT;
			for (int k = 0; k < BANKS - 1; k++) begin
				if (req[k]) d.bank = 3'(k + 2);
			end
		end

		// axi4-lite write: address and data taken in either order
		if (s_axi_awvalid && !q.aw_full) begin
			d.aw_full = 1'b1;
			d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_full) begin
			d.w_full = 1'b1;
			d.wdata  = s_axi_wdata;
			d.wstrb  = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
		if (q.aw_full && q.w_full && !q.bvalid) begin
			cur = reg_read(q, q.awaddr);
			for (int b = 0; b < 4; b++) begin
				merged[b*8 +: 8] = q.wstrb[b] ? q.wdata[b*8 +: 8] : cur[b*8 +: 8];
			end
			d.aw_full = 1'b0;
			d.w_full  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = cur[32] ? RESP_OKAY : RESP_SLVERR;
			unique case (q.awaddr)
				OFF_CTRL: begin
					d.inc_ack_mode  = merged[CTRL_INC_ACK];
					d.code_ack_mode = merged[CTRL_CODE_ACK];
					// policy only read when the init wait ends, and reset reloads restore; code 3 ignored
					if (merged[CTRL_POLICY +: 2] != 2'h3)
						d.policy = pwr_policy_t'(merged[CTRL_POLICY +: 2]);
				end
				OFF_LIMIT: begin
					d.limit = (merged[2:0] < LIMIT_MIN) ? LIMIT_MIN : merged[2:0];
				end
				OFF_TIMEOUT: begin
					if (merged[TO_W-1:0] < TIMEOUT_MIN)
						d.timeout = TIMEOUT_MIN;
					else if (merged[TO_W-1:0] > TIMEOUT_MAX || merged[31:TO_W] != '0)
						d.timeout = TIMEOUT_MAX;
					else
						d.timeout = merged[TO_W-1:0];
				end
				default: ;
			endcase
		end

		// axi4-lite read
		if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
		if (s_axi_arvalid && !q.rvalid) begin
			rd       = reg_read(q, s_axi_araddr);
			d.rvalid = 1'b1;
			d.rdata  = rd[31:0];
			d.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q               <= '0;
			q.seq           <= S_INIT;
			q.bank          <= BANK_DEFAULT;
			q.policy        <= POLICY_RST;
			q.limit         <= LIMIT_RST;
			q.timeout       <= TIMEOUT_RST;
			q.bresp         <= RESP_OKAY;
			q.rresp         <= RESP_OKAY;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready = ~q.aw_full;
	assign s_axi_wready  = ~q.w_full;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = ~q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;

	assign nv_write      = q.nv_we;
	assign nv_write_data = q.nv_data;
	assign position_code = q.pos;
	assign bank_active   = q.bank;

	genvar gi;
	generate
		for (gi = 0; gi < POSITIONS; gi++) begin : g_pos
			assign position_onehot[gi] = (q.pos == 3'(gi + 1));
		end
		for (gi = 0; gi < BANKS; gi++) begin : g_bank
			assign bank_onehot[gi] = (q.bank == 3'(gi + 1));
		end
	endgenerate

	// range and confirm alarms read straight off their hold counters; powerup alarm is its own flop
	assign range_alarm             = (q.range_cnt != '0);
	assign increment_confirm_alarm = (q.inc_cnt != '0);
	assign code_confirm_alarm      = (q.code_cnt != '0);
	assign powerup_alarm           = q.pwr_alarm;

endmodule // position_selector_group_arbiter

`default_nettype wire

// ---- dv/sel_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module sel_checker
	import sel_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = 10
) (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst_n,
	// arbiter
	input wire logic                 group_change_block,
	input wire logic [BANKS-2:0]     bank_request,
	input wire logic [2:0]           bank_active,
	input wire logic [BANKS-1:0]     bank_onehot,
	// selector
	input wire logic                 nv_write,
	input wire logic [2:0]           nv_write_data,
	input wire logic [POSITIONS-1:0] position_onehot,
	input wire logic [2:0]           position_code,
	// alarms
	input wire logic                 range_alarm,
	input wire logic                 increment_confirm_alarm,
	input wire logic                 code_confirm_alarm
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	//////////////////////////////////////////////////////////////////////////
	// helpers
	localparam int unsigned AL_LO = (ALARM_TICKS - 1) * TICK_CYCLES_P;
	localparam int unsigned AL_HI = (ALARM_TICKS + 1) * TICK_CYCLES_P;
	logic [2:0] exp_bank;
	logic [2:0] al;
	assign al = {range_alarm, increment_confirm_alarm, code_confirm_alarm};
	always_comb begin
		exp_bank = BANK_DEFAULT;
		for (int k = 2; k <= 6; k++) begin
			if (bank_request[k-2] || position_code == 3'(k))
				exp_bank = 3'(k);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// assertions
	a_bank_decode: assert property (bank_onehot == 6'(6'h01 << (bank_active - 3'h1)))
		else $error("bank one-hot does not match bank code");
	a_pos_decode: assert property (position_onehot == ((position_code == POS_NONE) ? 7'h00
		: 7'(7'h01 << (position_code - 3'h1)))) else $error("position one-hot mismatch");
	a_nv_data: assert property (nv_write |-> nv_write_data == position_code)
		else $error("stored word differs from position");
	a_nv_pulse: assert property (nv_write |=> !nv_write)
		else $error("store strobe longer than one cycle");
	a_block_hold: assert property (group_change_block [*5] |=> $stable(bank_active))
		else $error("bank moved while blocked");
	a_bank_select: assert property ((!group_change_block && $stable(bank_request)
		&& $stable(position_code)) [*5] |-> bank_active == exp_bank)
		else $error("wrong bank selected");
	a_alarm_discard: assert property (($rose(increment_confirm_alarm)
		|| $rose(code_confirm_alarm)) |-> !nv_write && $stable(position_code))
		else $error("position applied with confirm alarm");
	// alarms are tick timed, so a tick of slack either side
	for (genvar i = 0; i < 3; i++) begin : g_al
		int unsigned cnt_q;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				cnt_q <= 0;
			else
				cnt_q <= al[i] ? cnt_q + 1 : 0;
		end
		a_alarm_width: assert property ($fell(al[i]) |-> cnt_q >= AL_LO && cnt_q <= AL_HI)
			else $error("alarm width off");
	end
endmodule // sel_checker

bind position_selector_group_arbiter sel_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
	.clk, .rst_n, .group_change_block, .bank_request, .bank_active, .bank_onehot,
	.nv_write, .nv_write_data, .position_onehot, .position_code,
	.range_alarm, .increment_confirm_alarm, .code_confirm_alarm
);
`default_nettype wire

// ---- dv/pin_source_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_source_model #(
	parameter int unsigned GAP     = 8,
	parameter logic [2:0]  NV_INIT = 3'h0
) (
	// clock and bench request
	input  wire logic       clk,
	input  wire logic       step_go,
	// selector side
	input  wire logic       nv_write,
	input  wire logic [2:0] nv_write_data,
	output logic            increment_in,
	output logic [2:0]      nv_position
);
	int unsigned gap_q = 0;
	logic [2:0]  store_q = NV_INIT;
	// store has no reset: it must outlive the device reset
	always_ff @(posedge clk) begin
		if (nv_write)
			store_q <= nv_write_data;
		if (gap_q != 0)
			gap_q <= gap_q - 1;
		else if (step_go)
			gap_q <= GAP;
	end
	// requests inside the gap are dropped, rising edges stay at least GAP + 1 clocks apart
	assign increment_in = gap_q > GAP / 2;
	assign nv_position = store_q;
endmodule // pin_source_model
`default_nettype wire

// ---- dv/test_position_selector_group_arbiter.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_position_selector_group_arbiter;
	import sel_pkg::*;
	localparam int W_NV = 0, W_RG = 1, W_INC = 2, W_CODE = 3;
	logic        clk = 1'b0, rst_n = 1'b0, step_go = 1'b0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf, watch;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        increment_confirm = 0, code_confirm_input = 0, group_change_block = 0;
	logic [2:0]  code = '0, nv_position, nv_write_data, position_code, bank_active;
	logic [4:0]  bank_request = '0;
	logic        increment_in, nv_write, range_alarm, increment_confirm_alarm;
	logic        code_confirm_alarm, powerup_alarm;
	logic [6:0]  position_onehot;
	logic [5:0]  bank_onehot;
	int          fails = 0, num_checks = 0;
	assign watch = {code_confirm_alarm, increment_confirm_alarm, range_alarm, nv_write};

	position_selector_group_arbiter #(.TICK_CYCLES_P(10)) dut (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .increment_in, .increment_confirm,
		.code_bit_zero(code[0]), .code_bit_one(code[1]), .code_bit_two(code[2]),
		.code_confirm_input, .group_change_block, .bank_request, .nv_position,
		.nv_write, .nv_write_data, .position_onehot, .position_code, .bank_active,
		.bank_onehot, .range_alarm, .increment_confirm_alarm, .code_confirm_alarm,
		.powerup_alarm
	);
	// 50 ms is half a scaled tick, 8 clocks clears it
	pin_source_model #(.GAP(8), .NV_INIT(3'h0)) u_src (
		.clk, .step_go, .nv_write, .nv_write_data, .increment_in, .nv_position
	);

	//////////////////////////////////////////////////////////////////////////
	// tasks
	initial forever #20 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: response %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk_resp(s_axi_bresp, er);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk_resp(s_axi_rresp, er);
	endtask
	task automatic wait_for(input int idx, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (watch[idx] !== 1'b1 && n < lim);
		chk(n < lim, 1'b1);
	endtask
	task automatic step();
		@(posedge clk);
		step_go <= 1'b1;
		@(posedge clk);
		step_go <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	task automatic pulse(input bit which);
		@(posedge clk);
		if (which)
			code_confirm_input <= 1'b1;
		else
			increment_confirm <= 1'b1;
		// short pulse so the commit strobe lands after the caller starts watching
		repeat (2) @(posedge clk);
		code_confirm_input <= 1'b0;
		increment_confirm <= 1'b0;
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
	endtask

	//////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		repeat (10000) @(posedge clk);
		fails++;
		stop_test();
	end
	initial begin
		do_reset();
		chk(position_code, POS_NONE);
		chk(powerup_alarm, 1'b1);
		chk(bank_active, BANK_DEFAULT);
		rd_chk(OFF_CTRL, 0, RESP_OKAY);
		rd_chk(OFF_LIMIT, LIMIT_RST, RESP_OKAY);
		rd_chk(OFF_TIMEOUT, TIMEOUT_RST, RESP_OKAY);
		wr(OFF_LIMIT, 0, RESP_OKAY);
		rd_chk(OFF_LIMIT, LIMIT_MIN, RESP_OKAY);
		wr(OFF_TIMEOUT, 5, RESP_OKAY);
		rd_chk(OFF_TIMEOUT, TIMEOUT_MIN, RESP_OKAY);
		wr(OFF_TIMEOUT, 32'h3ff, RESP_OKAY);
		rd_chk(OFF_TIMEOUT, TIMEOUT_MAX, RESP_OKAY);
		wr(OFF_TIMEOUT, TIMEOUT_MIN, RESP_OKAY);
		wr(OFF_LIMIT, 4, RESP_OKAY);
		wr(OFF_STATUS, '1, RESP_OKAY);
		rd_chk(8'h10, 0, RESP_SLVERR);
		wr(8'h10, 1, RESP_SLVERR);
		// stepping, timeout mode, limit 4
		step();
		pulse(0);
		repeat (150) @(posedge clk);
		step();
		repeat (100) @(posedge clk);
		code <= 3'h2;
		repeat (100) @(posedge clk);
		chk(position_code, POS_NONE);
		code <= 3'h0;
		repeat (3) step();
		repeat (250) @(posedge clk);
		chk(position_code, POS_NONE);
		wait_for(W_NV, 100);
		chk(position_code, POS_FIRST);
		chk(powerup_alarm, 1'b0);
		// code path, timeout mode
		code <= 3'h3;
		step();
		wait_for(W_NV, 400);
		chk(position_code, 3'h3);
		repeat (5) @(posedge clk);
		chk(bank_active, 3'h3);
		code <= 3'h6;
		wait_for(W_RG, 20);
		chk(position_code, 3'h3);
		code <= 3'h0;
		// both paths in confirm mode
		wr(OFF_CTRL, 32'h3, RESP_OKAY);
		step();
		pulse(1);
		repeat (20) @(posedge clk);
		chk(position_code, 3'h3);
		pulse(0);
		wait_for(W_NV, 10);
		chk(position_code, 3'h4);
		step();
		wait_for(W_INC, 400);
		chk(position_code, 3'h4);
		code <= 3'h2;
		wait_for(W_CODE, 400);
		chk(position_code, 3'h4);
		code <= 3'h1;
		repeat (20) @(posedge clk);
		pulse(1);
		wait_for(W_NV, 10);
		chk(position_code, 3'h1);
		// arbiter
		bank_request <= 5'h0a;
		repeat (8) @(posedge clk);
		chk(bank_active, 3'h5);
		group_change_block <= 1'b1;
		repeat (8) @(posedge clk);
		bank_request <= 5'h10;
		repeat (8) @(posedge clk);
		chk(bank_active, 3'h5);
		group_change_block <= 1'b0;
		repeat (8) @(posedge clk);
		chk(bank_onehot, 6'h20);
		bank_request <= 5'h00;
		repeat (8) @(posedge clk);
		chk(bank_active, BANK_DEFAULT);
		// restore after power cycle
		do_reset();
		chk(position_code, 3'h1);
		chk(powerup_alarm, 1'b0);
		stop_test();
	end
endmodule // test_position_selector_group_arbiter
`default_nettype wire
